/* inc/hcu_pkg.sv */
`default_nettype none
package hcu_pkg;
  // Line format and timing
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned BAUD          = 9600;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned STOP_BITS     = 1;
  localparam int unsigned BIT_CYCLES    = CLK_HZ / BAUD;
  localparam int unsigned HALF_CYCLES   = BIT_CYCLES / 2;
  localparam int unsigned FIFO_DEPTH    = 8;
  localparam logic [7:0]  ASCII_LF      = 8'h0a;
  localparam logic [7:0]  ASCII_CR      = 8'h0d;
  localparam logic [7:0]  ASCII_SPACE   = 8'h20;
  localparam logic [7:0]  ASCII_TILDE   = 8'h7e;

  typedef enum logic [1:0] {
    HCU_IDLE  = 2'b00,
    HCU_START = 2'b01,
    HCU_DATA  = 2'b10,
    HCU_STOP  = 2'b11
  } hcu_state_type;
endpackage : hcu_pkg
`default_nettype wire

/* hdl/hcu_fifo.sv */
`default_nettype none
module hcu_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wrPtr;
  logic [AW-1:0]    next_rdPtr;
  logic [AW:0]      next_count;
  logic             doWr;
  logic             doRd;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always_comb begin
    next_wrPtr = doWr ? ((wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1) : wrPtr;
    next_rdPtr = doRd ? ((rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1) : rdPtr;
    next_count = count + (AW+1)'(doWr) - (AW+1)'(doRd);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr] <= inData;
    end
  end

  chk_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
    count <= (AW+1)'(DEPTH)) else $error("fifo count exceeds depth");
endmodule : hcu_fifo
`default_nettype wire

/* hdl/hcu_tx.sv */
`default_nettype none
module hcu_tx #(
  parameter int unsigned BIT_CYCLES = hcu_pkg::BIT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  output logic            txReady,
  output logic            txLine,
  output logic            txBusy
);
  localparam int unsigned CW = $clog2(BIT_CYCLES);

  hcu_pkg::hcu_state_type state;
  hcu_pkg::hcu_state_type next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [2:0]    bitIdx;
  logic [2:0]    next_bitIdx;
  logic [7:0]    shift;
  logic [7:0]    next_shift;
  logic          next_txLine;
  logic          bitEnd;

  assign bitEnd  = (cnt == CW'(BIT_CYCLES-1));
  // No flow-control input exists: a byte goes out as soon as one is offered while idle
  assign txReady = (state == hcu_pkg::HCU_IDLE);
  assign txBusy  = (state != hcu_pkg::HCU_IDLE);

  always_comb begin
    next_state  = state;
    next_cnt    = bitEnd ? '0 : cnt + 1'b1;
    next_bitIdx = bitIdx;
    next_shift  = shift;
    next_txLine = txLine;
    case (state)
      hcu_pkg::HCU_IDLE: begin
        next_cnt    = '0;
        next_txLine = 1'b1;
        if (txValid) begin
          next_shift  = txData;
          next_txLine = 1'b0;
          next_state  = hcu_pkg::HCU_START;
        end
      end
      hcu_pkg::HCU_START: begin
        if (bitEnd) begin
          next_txLine = shift[0];
          next_shift  = {1'b1, shift[7:1]};
          next_bitIdx = '0;
          next_state  = hcu_pkg::HCU_DATA;
        end
      end
      hcu_pkg::HCU_DATA: begin
        if (bitEnd) begin
          if (bitIdx == 3'(hcu_pkg::DATA_BITS-1)) begin
            next_txLine = 1'b1;
            next_state  = hcu_pkg::HCU_STOP;
          end else begin
            next_txLine = shift[0];
            next_shift  = {1'b1, shift[7:1]};
            next_bitIdx = bitIdx + 1'b1;
          end
        end
      end
      default: begin
        if (bitEnd) begin
          next_state = hcu_pkg::HCU_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state  <= hcu_pkg::HCU_IDLE;
      cnt    <= '0;
      bitIdx <= '0;
      shift  <= '0;
      txLine <= 1'b1;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      bitIdx <= next_bitIdx;
      shift  <= next_shift;
      txLine <= next_txLine;
    end
  end

  sequence s_tx_start;
    state == hcu_pkg::HCU_IDLE && txValid;
  endsequence

  chk_tx_start_low: assert property (@(posedge clk) disable iff (!rst_n)
    s_tx_start |=> !txLine) else $error("start bit not low");
  chk_tx_idle_high: assert property (@(posedge clk) disable iff (!rst_n)
    (state == hcu_pkg::HCU_IDLE && !$past(txValid)) |-> txLine)
    else $error("idle line not high");
  chk_tx_stop_high: assert property (@(posedge clk) disable iff (!rst_n)
    state == hcu_pkg::HCU_STOP |-> txLine) else $error("stop bit not high");
endmodule : hcu_tx
`default_nettype wire

/* hdl/host_command_uart.sv */
`default_nettype none
module host_command_uart #(
  parameter int unsigned BIT_CYCLES  = hcu_pkg::BIT_CYCLES,
  parameter int unsigned HALF_CYCLES = hcu_pkg::HALF_CYCLES,
  parameter int unsigned FIFO_DEPTH  = hcu_pkg::FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       lowEnergy,
  input  wire logic       rxLine,
  output logic            txLine,
  output logic [7:0]      rxData,
  output logic            rxValid,
  input  wire logic       rxReady,
  output logic            rxLineEnd,
  output logic            rxNonAscii,
  output logic            frameError,
  output logic            rxOverrun,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  output logic            txReady,
  output logic            txBusy
);
  localparam int unsigned CW = $clog2(BIT_CYCLES);

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  hcu_pkg::hcu_state_type state;
  hcu_pkg::hcu_state_type next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [2:0]    bitIdx;
  logic [2:0]    next_bitIdx;
  logic [7:0]    shift;
  logic [7:0]    next_shift;
  logic          rxPrev;
  logic          byteDone;
  logic          next_byteDone;
  logic          stopBad;
  logic          next_stopBad;
  logic          fifoInReady;
  logic          fifoOutValid;
  logic [7:0]    fifoOutData;
  logic          sampleEdge;
  logic          halfEdge;
  logic          next_frameError;
  logic          next_rxOverrun;

  assign sampleEdge = (cnt == CW'(BIT_CYCLES-1));
  assign halfEdge   = (cnt == CW'(HALF_CYCLES-1));

  // Printable ASCII or a line terminator counts as command text
  function automatic logic isText(input logic [7:0] b);
    isText = (b >= hcu_pkg::ASCII_SPACE && b <= hcu_pkg::ASCII_TILDE)
          || b == hcu_pkg::ASCII_CR || b == hcu_pkg::ASCII_LF;
  endfunction : isText

  function automatic logic isEol(input logic [7:0] b);
    isEol = (b == hcu_pkg::ASCII_CR) || (b == hcu_pkg::ASCII_LF);
  endfunction : isEol

  // lowEnergy is deliberately ignored by the datapath: the receiver never
  // gates its clock or sampling, so no byte is lost while waiting.
  always_comb begin
    next_state    = state;
    next_cnt      = sampleEdge ? '0 : cnt + 1'b1;
    next_bitIdx   = bitIdx;
    next_shift    = shift;
    next_byteDone = 1'b0;
    next_stopBad  = 1'b0;
    case (state)
      hcu_pkg::HCU_IDLE: begin
        next_cnt = '0;
        if (rxPrev && !rxLine) begin
          next_state = hcu_pkg::HCU_START;
        end
      end
      hcu_pkg::HCU_START: begin
        // Recheck the start bit at its centre to reject glitches
        if (halfEdge) begin
          next_cnt = '0;
          if (rxLine) begin
            next_state = hcu_pkg::HCU_IDLE;
          end else begin
            next_bitIdx = '0;
            next_state  = hcu_pkg::HCU_DATA;
          end
        end
      end
      hcu_pkg::HCU_DATA: begin
        if (sampleEdge) begin
          next_shift = {rxLine, shift[7:1]};
          if (bitIdx == 3'(hcu_pkg::DATA_BITS-1)) begin
            next_state = hcu_pkg::HCU_STOP;
          end else begin
            next_bitIdx = bitIdx + 1'b1;
          end
        end
      end
      default: begin
        if (sampleEdge) begin
          next_byteDone = 1'b1;
          next_stopBad  = !rxLine;
          next_state    = hcu_pkg::HCU_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= hcu_pkg::HCU_IDLE;
      cnt      <= '0;
      bitIdx   <= '0;
      shift    <= '0;
      rxPrev   <= 1'b1;
      byteDone <= 1'b0;
      stopBad  <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      bitIdx   <= next_bitIdx;
      shift    <= next_shift;
      rxPrev   <= rxLine;
      byteDone <= next_byteDone;
      stopBad  <= next_stopBad;
    end
  end

  // ----------------------------------------
  // Receive buffer and status
  // ----------------------------------------
  // A byte with a bad stop bit is dropped rather than buffered
  hcu_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inData   (shift),
    .inValid  (byteDone && !stopBad),
    .inReady  (fifoInReady),
    .outData  (fifoOutData),
    .outValid (fifoOutValid),
    .outReady (rxReady)
  );

  assign rxValid = fifoOutValid;
  assign rxData  = fifoOutData;

  // Sticky flags; cleared only by reset since no register port exists
  always_comb begin
    next_frameError = frameError || (byteDone && stopBad);
    next_rxOverrun  = rxOverrun || (byteDone && !stopBad && !fifoInReady);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frameError <= 1'b0;
      rxOverrun  <= 1'b0;
      rxLineEnd  <= 1'b0;
      rxNonAscii <= 1'b0;
    end else begin
      frameError <= next_frameError;
      rxOverrun  <= next_rxOverrun;
      rxLineEnd  <= fifoOutValid && rxReady && isEol(fifoOutData);
      rxNonAscii <= fifoOutValid && rxReady && !isText(fifoOutData);
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  hcu_tx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_tx (
    .clk     (clk),
    .rst_n   (rst_n),
    .txData  (txData),
    .txValid (txValid),
    .txReady (txReady),
    .txLine  (txLine),
    .txBusy  (txBusy)
  );

  // ----------------------------------------
  // Frame timing monitor
  // ----------------------------------------
  // Cycles since the start edge; only the checks read it, so synthesis
  // removes it and it costs nothing in silicon
  localparam int unsigned FW = $clog2(HALF_CYCLES + 10 * BIT_CYCLES);

  logic [FW-1:0] frameCycles;
  logic [FW-1:0] next_frameCycles;

  always_comb begin
    if (state == hcu_pkg::HCU_IDLE) begin
      next_frameCycles = '0;
    end else begin
      next_frameCycles = frameCycles + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frameCycles <= '0;
    end else begin
      frameCycles <= next_frameCycles;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Steps of one inbound frame, in the order they occur
  sequence s_rx_fall;
    state == hcu_pkg::HCU_IDLE && rxPrev && !rxLine;
  endsequence

  sequence s_rx_half_good;
    state == hcu_pkg::HCU_START && halfEdge && !rxLine;
  endsequence

  sequence s_rx_half_glitch;
    state == hcu_pkg::HCU_START && halfEdge && rxLine;
  endsequence

  sequence s_rx_last_bit;
    state == hcu_pkg::HCU_DATA && sampleEdge && bitIdx == 3'(hcu_pkg::DATA_BITS-1);
  endsequence

  sequence s_rx_stop_sample;
    state == hcu_pkg::HCU_STOP && sampleEdge;
  endsequence

  sequence s_rx_good_byte;
    byteDone && !stopBad;
  endsequence

  // Receive framing, one step of the frame at a time
  chk_rx_start_seen: assert property (@(posedge clk) disable iff (!rst_n)
    s_rx_fall |=> state == hcu_pkg::HCU_START) else $error("start edge missed");
  chk_rx_half_good: assert property (@(posedge clk) disable iff (!rst_n)
    s_rx_half_good |=> state == hcu_pkg::HCU_DATA) else $error("start bit dropped");
  chk_rx_glitch_drop: assert property (@(posedge clk) disable iff (!rst_n)
    s_rx_half_glitch |=> state == hcu_pkg::HCU_IDLE) else $error("glitch taken as start");
  chk_rx_data_order: assert property (@(posedge clk) disable iff (!rst_n)
    (state == hcu_pkg::HCU_DATA && sampleEdge) |=> shift[7] == $past(rxLine))
    else $error("data bit not shifted in at the top");
  chk_rx_last_bit: assert property (@(posedge clk) disable iff (!rst_n)
    s_rx_last_bit |=> state == hcu_pkg::HCU_STOP) else $error("stop bit not reached");
  // Stop is sampled half a bit plus nine whole bits after the start edge
  chk_rx_bit_time: assert property (@(posedge clk) disable iff (!rst_n)
    s_rx_stop_sample |-> frameCycles == FW'(HALF_CYCLES + 9 * BIT_CYCLES - 1))
    else $error("stop bit sampled off centre");
  chk_rx_done_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    s_rx_stop_sample |=> byteDone) else $error("byte end not signalled");
  chk_rx_frame_len: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(byteDone) |-> $past(state) == hcu_pkg::HCU_STOP)
    else $error("byte ended outside stop bit");
  chk_rx_frame_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (byteDone && stopBad) |=> frameError) else $error("frame error not flagged");

  // The receiver runs the same in every power mode
  chk_rx_lowpower_on: assert property (@(posedge clk) disable iff (!rst_n)
    (s_rx_fall and lowEnergy) |=> state != hcu_pkg::HCU_IDLE)
    else $error("receiver idle in low energy");

  // Receive buffer and flags
  chk_rx_good_push: assert property (@(posedge clk) disable iff (!rst_n)
    (s_rx_good_byte and fifoInReady) |=> fifoOutValid)
    else $error("received byte not buffered");
  // A pop in the same cycle does not make room, so that byte is lost too
  chk_rx_lost_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (s_rx_good_byte and !fifoInReady) |=> rxOverrun)
    else $error("lost byte not flagged");
  chk_rx_valid_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (fifoOutValid && !rxReady) |=> fifoOutValid) else $error("buffered byte vanished");
  chk_rx_eol_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (fifoOutValid && rxReady && fifoOutData == hcu_pkg::ASCII_CR) |=> rxLineEnd)
    else $error("line end not flagged");
  chk_rx_high_code: assert property (@(posedge clk) disable iff (!rst_n)
    (fifoOutValid && rxReady && fifoOutData > hcu_pkg::ASCII_TILDE) |=> rxNonAscii)
    else $error("code above text range not flagged");

  // Transmit pin as the host sees it
  chk_tx_idle_pin: assert property (@(posedge clk) disable iff (!rst_n)
    !txBusy |-> txLine) else $error("transmit pin low while idle");
  chk_tx_fall_busy: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(txLine) |-> txBusy) else $error("transmit pin fell outside a frame");
  chk_tx_take_busy: assert property (@(posedge clk) disable iff (!rst_n)
    (txValid && txReady) |=> (txBusy && !txReady)) else $error("second byte taken while busy");
endmodule : host_command_uart
`default_nettype wire

/* tb/hcu_host_model.sv */
`default_nettype none
module hcu_host_model #(
  parameter int unsigned BIT_CYCLES = 16
) (
  input  wire logic clk,
  input  wire logic txLine,
  output var  logic rxLine
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [8:0] gotQ[$];

  // ------------------------------------------------------------
  // Host to module
  // ------------------------------------------------------------
  // Between frames the model itself drives the line high
  initial rxLine = 1'b1;

  // Sent without waiting on any flow-control signal
  task automatic send_byte(input logic [7:0] value, input logic stopBit);
    logic [9:0] frame;
    frame = {stopBit, value, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      rxLine = frame[i];
      repeat (BIT_CYCLES - 1) @(negedge clk);
    end
    @(negedge clk);
    rxLine = 1'b1;
  endtask : send_byte

  // A low pulse shorter than half a bit, which must not start a frame
  task automatic glitch(input int unsigned width);
    @(negedge clk);
    rxLine = 1'b0;
    repeat (width) @(negedge clk);
    rxLine = 1'b1;
  endtask : glitch

  // ------------------------------------------------------------
  // Module to host
  // ------------------------------------------------------------
  // Samples mid-bit; the stop level is kept beside the data for checking
  always begin
    logic [9:0] bits;
    @(negedge txLine);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    bits[0] = txLine;
    for (int i = 1; i < 10; i++) begin
      repeat (BIT_CYCLES) @(posedge clk);
      bits[i] = txLine;
    end
    gotQ.push_back(bits[9:1]);
  end
endmodule : hcu_host_model
`default_nettype wire

/* tb/host_command_uart_tb.sv */
`default_nettype none
module host_command_uart_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // Short bit time keeps the run small; every wait but the reset delay, the two-cycle flag watch in pop and the LIMIT guard derives from it
  localparam int unsigned BITS  = 16;
  localparam int unsigned LIMIT = 20000;

  logic       clk = 1'b0;
  logic       rst_n, lowEnergy, rxLine, txLine, rxValid, rxReady;
  logic       rxLineEnd, rxNonAscii, frameError, rxOverrun;
  logic       txValid, txReady, txBusy;
  logic [7:0] rxData, txData;
  int         failures, samplesChecked, cycles;

  always #25 clk = ~clk;

  host_command_uart #(
    .BIT_CYCLES  (BITS),
    .HALF_CYCLES (BITS / 2),
    .FIFO_DEPTH  (hcu_pkg::FIFO_DEPTH)
  ) dut (
    .clk        (clk),
    .rst_n      (rst_n),
    .lowEnergy  (lowEnergy),
    .rxLine     (rxLine),
    .txLine     (txLine),
    .rxData     (rxData),
    .rxValid    (rxValid),
    .rxReady    (rxReady),
    .rxLineEnd  (rxLineEnd),
    .rxNonAscii (rxNonAscii),
    .frameError (frameError),
    .rxOverrun  (rxOverrun),
    .txData     (txData),
    .txValid    (txValid),
    .txReady    (txReady),
    .txBusy     (txBusy)
  );

  hcu_host_model #(.BIT_CYCLES(BITS)) host (
    .clk    (clk),
    .txLine (txLine),
    .rxLine (rxLine)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [8:0] seen, input logic [8:0] expected);
    samplesChecked++;
    if (seen !== expected) begin
      failures++;
      $display("[ERR] %0t ns: saw %h expected %h", $time, seen, expected);
    end
  endtask : check

  // txReady only moves on a rising edge, so a high level seen here still
  // stands at the next rising edge, which takes the byte
  task automatic send(input logic [7:0] value);
    int n;
    n = 0;
    @(negedge clk);
    txData  = value;
    txValid = 1'b1;
    while (txReady !== 1'b1 && n < 40 * BITS) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    @(negedge clk);
    txValid = 1'b0;
    @(negedge clk);
    check({7'h00, txBusy, txLine}, 9'h002);
  endtask : send

  // Pulse flags may land one cycle late, so two cycles are watched
  task automatic pop(input logic [7:0] value, input logic [1:0] flags);
    logic [1:0] seen;
    int         n;
    seen = 2'b00;
    n    = 0;
    while (rxValid !== 1'b1 && n < 40 * BITS) begin
      @(negedge clk);
      n++;
    end
    rxReady = 1'b1;
    check({1'b0, rxData}, {1'b0, value});
    @(negedge clk);
    rxReady = 1'b0;
    repeat (2) begin
      seen = seen | {rxLineEnd, rxNonAscii};
      @(negedge clk);
    end
    check({7'h00, seen}, {7'h00, flags});
  endtask : pop

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_reset();
    check({8'h00, txLine}, 9'h001);
    check({7'h00, txReady, rxValid}, 9'h002);
    check({7'h00, frameError, rxOverrun}, 9'h000);
    $display("test_reset done");
  endtask : test_reset

  // Second request arrives while busy and must wait its turn
  task automatic test_tx();
    lowEnergy = 1'b1;
    send(8'h41);
    send(8'ha5);
    repeat (12 * BITS) @(negedge clk);
    check(host.gotQ.pop_front(), 9'h141);
    check(host.gotQ.pop_front(), 9'h1a5);
    $display("test_tx done");
  endtask : test_tx

  task automatic test_rx_ascii();
    logic [7:0] codes [6] = '{hcu_pkg::ASCII_SPACE, hcu_pkg::ASCII_TILDE, 8'h7f,
                              8'h1f, hcu_pkg::ASCII_CR, hcu_pkg::ASCII_LF};
    logic [1:0] marks [6] = '{2'b00, 2'b00, 2'b01, 2'b01, 2'b10, 2'b10};
    for (int i = 0; i < 6; i++) begin
      host.send_byte(codes[i], 1'b1);
      pop(codes[i], marks[i]);
    end
    check({7'h00, frameError, rxOverrun}, 9'h000);
    $display("test_rx_ascii done");
  endtask : test_rx_ascii

  // Reader stalls while one byte more than the buffer holds arrives
  task automatic test_overrun();
    for (int i = 0; i <= int'(hcu_pkg::FIFO_DEPTH); i++) begin
      host.send_byte(8'h30 + 8'(i), 1'b1);
    end
    repeat (BITS) @(negedge clk);
    check({7'h00, rxOverrun, rxValid}, 9'h003);
    for (int i = 0; i < int'(hcu_pkg::FIFO_DEPTH); i++) begin
      pop(8'h30 + 8'(i), 2'b00);
    end
    check({8'h00, rxValid}, 9'h000);
    $display("test_overrun done");
  endtask : test_overrun

  // A short low pulse must leave the receiver idle and ready for a real byte
  task automatic test_glitch();
    host.glitch(BITS / 4);
    repeat (2 * BITS) @(negedge clk);
    check({7'h00, frameError, rxValid}, 9'h000);
    host.send_byte(8'h4f, 1'b1);
    pop(8'h4f, 2'b00);
    $display("test_glitch done");
  endtask : test_glitch

  task automatic test_frame_error();
    host.send_byte(8'h55, 1'b0);
    repeat (BITS) @(negedge clk);
    check({7'h00, frameError, rxValid}, 9'h002);
    $display("test_frame_error done");
  endtask : test_frame_error

  // ------------------------------------------------------------
  // Sequence and hang guard
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    cycles    = 0;
    rst_n     = 1'b0;
    lowEnergy = 1'b0;
    rxReady   = 1'b0;
    txData    = 8'h00;
    txValid   = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    test_reset();
    test_tx();
    test_rx_ascii();
    test_overrun();
    test_glitch();
    test_frame_error();
    report_and_stop();
  end
endmodule : host_command_uart_tb
`default_nettype wire
